// ==== iow_pkg.sv ====
// Purpose: shared constants and carrier types for the wide-register io space
// Assumes: 16-bit cpu data address, 8-bit data, single system clock
// Notes: peripheral bases and window sizes are kept here once
package iow_pkg;
  localparam logic [15:0] IOW_SINGLE_CYCLE_TOP = 16'h003f;
  localparam logic [15:0] IOW_BIT_ACCESS_TOP = 16'h001f;
  localparam logic [15:0] IOW_BASE_VPORT0 = 16'h0000;
  localparam logic [15:0] IOW_BASE_VPORT1 = 16'h0004;
  localparam logic [15:0] IOW_BASE_VPORT2 = 16'h0008;
  localparam logic [15:0] IOW_BASE_GPIO = 16'h001c;
  localparam logic [15:0] IOW_BASE_CPU = 16'h0030;
  localparam logic [15:0] IOW_BASE_CRCSCAN = 16'h0120;
  localparam logic [15:0] IOW_BASE_RTC = 16'h0140;
  localparam logic [15:0] IOW_BASE_USART1 = 16'h0820;
  localparam logic [15:0] IOW_BASE_TWI = 16'h08a0;
  localparam logic [15:0] IOW_BASE_SPI = 16'h08c0;
  localparam logic [15:0] IOW_BASE_TCA = 16'h0a00;
  localparam logic [15:0] IOW_BASE_TCB0 = 16'h0a80;
  localparam logic [15:0] IOW_BASE_TCB1 = 16'h0a90;
  // window sizes in bytes
  localparam logic [15:0] IOW_SIZE_VPORT = 16'h0004;
  localparam logic [15:0] IOW_SIZE_GPIO = 16'h0004;
  localparam logic [15:0] IOW_SIZE_CPU = 16'h0010;
  localparam logic [15:0] IOW_SIZE_SMALL = 16'h0010;
  localparam logic [15:0] IOW_SIZE_MID = 16'h0020;
  localparam logic [15:0] IOW_SIZE_TCA = 16'h0040;
  localparam int IOW_NSEL = 13;
  // select indices
  localparam int IOW_SEL_VPORT0 = 0;
  localparam int IOW_SEL_VPORT1 = 1;
  localparam int IOW_SEL_VPORT2 = 2;
  localparam int IOW_SEL_GPIO = 3;
  localparam int IOW_SEL_CPU = 4;
  localparam int IOW_SEL_CRCSCAN = 5;
  localparam int IOW_SEL_RTC = 6;
  localparam int IOW_SEL_USART1 = 7;
  localparam int IOW_SEL_TWI = 8;
  localparam int IOW_SEL_SPI = 9;
  localparam int IOW_SEL_TCA = 10;
  localparam int IOW_SEL_TCB0 = 11;
  localparam int IOW_SEL_TCB1 = 12;
  // wide register demo instances, placed in the timer windows
  localparam logic [15:0] IOW_WIDE16_ADDR = 16'h0a8a;
  localparam logic [15:0] IOW_WIDE32_ADDR = 16'h0a20;
  localparam logic [7:0] IOW_BYTE_RESET = 8'h00;
  localparam logic [7:0] IOW_UNMAPPED_READ = 8'h00;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } iow_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic hit;
  } iow_rsp_t;

  typedef enum logic [1:0] {
    IOW_BIT_NONE = 2'b00,
    IOW_BIT_SET = 2'b01,
    IOW_BIT_CLEAR = 2'b10
  } iow_bitop_t;
endpackage

// ==== iow_decode.sv ====
// Purpose: combinational peripheral base decoder
// Assumes: windows never overlap
// Notes: one-hot select, zero when the address is unmapped
`timescale 1ns/1ps
module iow_decode
  import iow_pkg::*;
(
  input wire logic [15:0] addr,
  output logic [IOW_NSEL-1:0] sel,
  output logic single_cycle,
  output logic bit_access
);
  logic [15:0] base_tab [IOW_NSEL];
  logic [15:0] size_tab [IOW_NSEL];
  always_comb begin
    base_tab[IOW_SEL_VPORT0] = IOW_BASE_VPORT0;
    base_tab[IOW_SEL_VPORT1] = IOW_BASE_VPORT1;
    base_tab[IOW_SEL_VPORT2] = IOW_BASE_VPORT2;
    base_tab[IOW_SEL_GPIO] = IOW_BASE_GPIO;
    base_tab[IOW_SEL_CPU] = IOW_BASE_CPU;
    base_tab[IOW_SEL_CRCSCAN] = IOW_BASE_CRCSCAN;
    base_tab[IOW_SEL_RTC] = IOW_BASE_RTC;
    base_tab[IOW_SEL_USART1] = IOW_BASE_USART1;
    base_tab[IOW_SEL_TWI] = IOW_BASE_TWI;
    base_tab[IOW_SEL_SPI] = IOW_BASE_SPI;
    base_tab[IOW_SEL_TCA] = IOW_BASE_TCA;
    base_tab[IOW_SEL_TCB0] = IOW_BASE_TCB0;
    base_tab[IOW_SEL_TCB1] = IOW_BASE_TCB1;
    size_tab[IOW_SEL_VPORT0] = IOW_SIZE_VPORT;
    size_tab[IOW_SEL_VPORT1] = IOW_SIZE_VPORT;
    size_tab[IOW_SEL_VPORT2] = IOW_SIZE_VPORT;
    size_tab[IOW_SEL_GPIO] = IOW_SIZE_GPIO;
    size_tab[IOW_SEL_CPU] = IOW_SIZE_CPU;
    size_tab[IOW_SEL_CRCSCAN] = IOW_SIZE_SMALL;
    size_tab[IOW_SEL_RTC] = IOW_SIZE_MID;
    size_tab[IOW_SEL_USART1] = IOW_SIZE_MID;
    size_tab[IOW_SEL_TWI] = IOW_SIZE_MID;
    size_tab[IOW_SEL_SPI] = IOW_SIZE_SMALL;
    size_tab[IOW_SEL_TCA] = IOW_SIZE_TCA;
    size_tab[IOW_SEL_TCB0] = IOW_SIZE_SMALL;
    size_tab[IOW_SEL_TCB1] = IOW_SIZE_SMALL;
  end
  for (genvar i = 0; i < IOW_NSEL; i++) begin : g_sel
    assign sel[i] = (addr >= base_tab[i]) && (addr < 16'(base_tab[i] + size_tab[i]));
  end
  assign single_cycle = (addr <= IOW_SINGLE_CYCLE_TOP);
  assign bit_access = (addr <= IOW_BIT_ACCESS_TOP);
endmodule // iow_decode

// ==== iow_space.sv ====
// Purpose: io register space with byte registers and staged 16/32-bit registers
// Assumes: cpu bus master on clk_sys, one access per cycle, rd and wr never together
// Notes: read data is registered and valid one cycle after the read strobe
// How it works
// - addresses 0x00..0x3f decode as single-cycle, but byte registers exist only below 0x20 inside a mapped window
// - mapped addresses up to 0x1f support single-bit set, clear and test
// - wide registers reach the byte bus through a shared staging latch
// - low byte write loads only the staging latch
// - high byte write stores high byte and moves latch into low byte
// - low byte read returns low byte and latches the high byte
// - high byte read returns the latch, not the live high byte
// - 32-bit registers use three latches; lsb read captures, msb write commits
// - decoder places fast ports at 0, 4, 8, gpio at 1c, cpu at 30
// - decoder selects crc scan at 0120 and real-time counter at 0140
// - decoder selects timer a at 0a00, timers b at 0a80 and 0a90
// - decoder selects usart at 0820, two-wire at 08a0, spi at 08c0
`timescale 1ns/1ps
module iow_space
  import iow_pkg::*;
#(
  parameter int LOW_REGS = 32
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire iow_req_t req,
  input wire iow_bitop_t bit_op,
  input wire logic [2:0] bit_idx,
  output iow_rsp_t rsp,
  output logic [IOW_NSEL-1:0] sel_out,
  output logic bit_test,
  output logic [15:0] wide16_value,
  output logic [31:0] wide32_value
);
  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic [IOW_NSEL-1:0] sel;
  logic single_cycle;
  logic bit_access;
  iow_decode u_dec (
    .addr(req.addr),
    .sel(sel),
    .single_cycle(single_cycle),
    .bit_access(bit_access)
  );
  logic lo_hit;
  logic [4:0] lo_idx;
  logic w16_lo, w16_hi, w32_b0, w32_b1, w32_b2, w32_b3;
  always_comb begin
    lo_hit = single_cycle && (sel != '0) && (req.addr < 16'(LOW_REGS));
    lo_idx = req.addr[4:0];
    w16_lo = (req.addr == IOW_WIDE16_ADDR);
    w16_hi = (req.addr == 16'(IOW_WIDE16_ADDR + 16'h0001));
    w32_b0 = (req.addr == IOW_WIDE32_ADDR);
    w32_b1 = (req.addr == 16'(IOW_WIDE32_ADDR + 16'h0001));
    w32_b2 = (req.addr == 16'(IOW_WIDE32_ADDR + 16'h0002));
    w32_b3 = (req.addr == 16'(IOW_WIDE32_ADDR + 16'h0003));
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte registers of the low space, flip-flops indexed by address
  logic [7:0] lo_reg [LOW_REGS];
  logic [7:0] lo_next [LOW_REGS];
  always_comb begin
    for (int i = 0; i < LOW_REGS; i++) begin
      lo_next[i] = lo_reg[i];
    end
    if (lo_hit && req.wr) begin
      lo_next[lo_idx] = req.wdata;
    end else if (lo_hit && bit_access && bit_op == IOW_BIT_SET) begin
      lo_next[lo_idx] = lo_reg[lo_idx] | (8'h01 << bit_idx);
    end else if (lo_hit && bit_access && bit_op == IOW_BIT_CLEAR) begin
      lo_next[lo_idx] = lo_reg[lo_idx] & ~(8'h01 << bit_idx);
    end
  end
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < LOW_REGS; i++) begin
      lo_reg[i] <= rst ? IOW_BYTE_RESET : lo_next[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wide registers and the shared staging latches
  // one latch set is shared by the 16-bit and 32-bit registers, so an isr touching either one must save it
  logic [15:0] w16_reg, w16_next;
  logic [31:0] w32_reg, w32_next;
  logic [23:0] temp_reg, temp_next;
  always_comb begin
    w16_next = w16_reg;
    w32_next = w32_reg;
    temp_next = temp_reg;
    if (req.wr) begin
      if (w16_lo) temp_next[7:0] = req.wdata;
      if (w16_hi) w16_next = {req.wdata, temp_reg[7:0]};
      if (w32_b0) temp_next[7:0] = req.wdata;
      if (w32_b1) temp_next[15:8] = req.wdata;
      if (w32_b2) temp_next[23:16] = req.wdata;
      if (w32_b3) w32_next = {req.wdata, temp_reg};
    end else if (req.rd) begin
      if (w16_lo) temp_next[7:0] = w16_reg[15:8];
      if (w32_b0) temp_next = w32_reg[31:8];
    end
  end
  always_ff @(posedge clk_sys) begin
    w16_reg <= rst ? 16'h0000 : w16_next;
    w32_reg <= rst ? 32'h0000_0000 : w32_next;
    temp_reg <= rst ? 24'h00_0000 : temp_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path and outputs
  iow_rsp_t rsp_next;
  logic bit_test_next;
  always_comb begin
    rsp_next.rdata = IOW_UNMAPPED_READ;
    rsp_next.hit = lo_hit || w16_lo || w16_hi || w32_b0 || w32_b1 || w32_b2 || w32_b3;
    if (req.rd) begin
      if (lo_hit) rsp_next.rdata = lo_reg[lo_idx];
      else if (w16_lo) rsp_next.rdata = w16_reg[7:0];
      else if (w16_hi) rsp_next.rdata = temp_reg[7:0];
      else if (w32_b0) rsp_next.rdata = w32_reg[7:0];
      else if (w32_b1) rsp_next.rdata = temp_reg[7:0];
      else if (w32_b2) rsp_next.rdata = temp_reg[15:8];
      else if (w32_b3) rsp_next.rdata = temp_reg[23:16];
    end
    bit_test_next = lo_hit && bit_access && lo_reg[lo_idx][bit_idx];
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rsp <= '0;
      sel_out <= '0;
      bit_test <= 1'b0;
      wide16_value <= 16'h0000;
      wide32_value <= 32'h0000_0000;
    end else begin
      rsp <= rsp_next;
      sel_out <= (req.rd || req.wr) ? sel : '0;
      bit_test <= bit_test_next;
      wide16_value <= w16_next;
      wide32_value <= w32_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_lo_write_no_commit;
    @(posedge clk_sys) disable iff (rst)
      (req.wr && w16_lo) |=> (w16_reg == $past(w16_reg)) && (temp_reg[7:0] == $past(req.wdata));
  endproperty
  a_lo_write_no_commit: assert property (p_lo_write_no_commit) else $error("low write changed value");
  sequence s_lo_wr;
    req.wr && w16_lo;
  endsequence
  sequence s_hi_wr;
    req.wr && w16_hi;
  endsequence
  // the master leaves one idle cycle between accesses, so the pair is lo, gap, hi
  property p_pair_commit;
    @(posedge clk_sys) disable iff (rst)
      s_lo_wr ##1 !req.wr ##1 s_hi_wr |=> (w16_reg == {$past(req.wdata), $past(req.wdata, 3)});
  endproperty
  a_pair_commit: assert property (p_pair_commit) else $error("16-bit pair not committed");
  property p_lo_read_capture;
    @(posedge clk_sys) disable iff (rst)
      (req.rd && !req.wr && w16_lo) |=> (temp_reg[7:0] == $past(w16_reg[15:8])) && (rsp.rdata == $past(w16_reg[7:0]));
  endproperty
  a_lo_read_capture: assert property (p_lo_read_capture) else $error("low read capture wrong");
  property p_hi_read_temp;
    @(posedge clk_sys) disable iff (rst)
      (req.rd && !req.wr && w16_hi) |=> (rsp.rdata == $past(temp_reg[7:0]));
  endproperty
  a_hi_read_temp: assert property (p_hi_read_temp) else $error("high read not from latch");
  property p_w32_commit;
    @(posedge clk_sys) disable iff (rst)
      (req.wr && w32_b3) |=> (w32_reg == {$past(req.wdata), $past(temp_reg)});
  endproperty
  a_w32_commit: assert property (p_w32_commit) else $error("32-bit commit wrong");
  property p_unmapped_zero;
    @(posedge clk_sys) disable iff (rst)
      (req.rd && !rsp_next.hit) |=> (rsp.rdata == 8'h00);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_bit_set;
    @(posedge clk_sys) disable iff (rst)
      (lo_hit && bit_access && !req.wr && bit_op == IOW_BIT_SET) |=> lo_reg[$past(lo_idx)][$past(bit_idx)];
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set failed");
  property p_decode_bases;
    @(posedge clk_sys) disable iff (rst)
      (req.rd && req.addr == IOW_BASE_TCB1) |=> sel_out[IOW_SEL_TCB1] && !sel_out[IOW_SEL_TCB0];
  endproperty
  a_decode_bases: assert property (p_decode_bases) else $error("timer b decode wrong");
  property p_single_cycle;
    @(posedge clk_sys) disable iff (rst)
      (req.addr > IOW_SINGLE_CYCLE_TOP) |-> !lo_hit;
  endproperty
  a_single_cycle: assert property (p_single_cycle) else $error("low space beyond 0x3f");
endmodule // iow_space

// ==== iow_cpu_model.sv ====
// Purpose: cpu data bus master model driving the io space
// Assumes: one access per call, launched and dropped at rising edges
// Notes: idle cycles show inverted address and data so stale values never pass
`timescale 1ns/1ps
module iow_cpu_model
  import iow_pkg::*;
(
  input wire logic clk_sys,
  output iow_req_t req,
  output iow_bitop_t bit_op,
  output logic [2:0] bit_idx
);
  initial begin
    req = '0;
    bit_op = IOW_BIT_NONE;
    bit_idx = 3'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // callers keep low before high, lsb read first, msb write last
  // no interrupt source here, so the shared latch is never disturbed mid pair
  // writes stay on mapped places except two deliberate stray writes
  task automatic access(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d,
                        input iow_bitop_t op, input logic [2:0] b);
    @(posedge clk_sys);
    req <= '{addr: a, wr: w, rd: r, wdata: d};
    bit_op <= op;
    bit_idx <= b;
    @(posedge clk_sys);
    req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    bit_op <= IOW_BIT_NONE;
    #1;
  endtask
endmodule // iow_cpu_model

// ==== testbench.sv ====
// Purpose: self-checking bench for the wide-register io space
// Assumes: answers one cycle after the taken edge
// Notes: wide copies are sampled two edges late, although they load at the same edge as the wide registers
`timescale 1ns/1ps
module testbench
  import iow_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  iow_req_t req;
  iow_bitop_t bit_op;
  logic [2:0] bit_idx;
  iow_rsp_t rsp;
  logic [IOW_NSEL-1:0] sel_out;
  logic bit_test;
  logic [15:0] wide16_value;
  logic [31:0] wide32_value;
  int miscompares = 0;
  int n_tests = 0;
  always #5 clk_sys = ~clk_sys;
  iow_cpu_model u_iow_cpu_model(.clk_sys(clk_sys), .req(req), .bit_op(bit_op), .bit_idx(bit_idx));
  iow_space u_iow_space(.clk_sys(clk_sys), .rst(rst), .req(req), .bit_op(bit_op), .bit_idx(bit_idx),
    .rsp(rsp), .sel_out(sel_out), .bit_test(bit_test), .wide16_value(wide16_value),
    .wide32_value(wide32_value));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d);
    u_iow_cpu_model.access(a, w, r, d, IOW_BIT_NONE, 3'h0);
  endtask
  task automatic wait2();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_decode();
    logic [15:0] bases [IOW_NSEL];
    bases = '{IOW_BASE_VPORT0, IOW_BASE_VPORT1, IOW_BASE_VPORT2, IOW_BASE_GPIO, IOW_BASE_CPU,
      IOW_BASE_CRCSCAN, IOW_BASE_RTC, IOW_BASE_USART1, IOW_BASE_TWI, IOW_BASE_SPI, IOW_BASE_TCA,
      IOW_BASE_TCB0, IOW_BASE_TCB1};
    for (int i = 0; i < IOW_NSEL; i++) begin
      acc(bases[i], 1'b0, 1'b1, 8'h00);
      check(32'(sel_out), 32'h1 << i);
    end
    acc(16'h0040, 1'b0, 1'b1, 8'h00);
    check(32'({rsp, sel_out}), 32'h0);
  endtask
  task automatic t_low();
    acc(16'h001f, 1'b1, 1'b0, 8'ha5);
    acc(16'h001f, 1'b0, 1'b1, 8'h00);
    check(32'(rsp.rdata), 32'ha5);
    check(32'(rsp.hit), 32'h1);
    u_iow_cpu_model.access(16'h001f, 1'b0, 1'b0, 8'h00, IOW_BIT_SET, 3'h1);
    u_iow_cpu_model.access(16'h001f, 1'b0, 1'b0, 8'h00, IOW_BIT_CLEAR, 3'h5);
    acc(16'h001f, 1'b0, 1'b1, 8'h00);
    check(32'(rsp.rdata), 32'h87);
    u_iow_cpu_model.access(16'h001f, 1'b0, 1'b0, 8'h00, IOW_BIT_NONE, 3'h7);
    check(32'(bit_test), 32'h1);
    u_iow_cpu_model.access(16'h001f, 1'b0, 1'b0, 8'h00, IOW_BIT_NONE, 3'h6);
    check(32'(bit_test), 32'h0);
  endtask
  // the odd high write after the low read commits the latch captured by that read
  task automatic t_wide16();
    acc(IOW_WIDE16_ADDR, 1'b1, 1'b0, 8'h34);
    wait2();
    check(32'(wide16_value), 32'h0);
    acc(IOW_WIDE16_ADDR + 16'h1, 1'b1, 1'b0, 8'h12);
    wait2();
    check(32'(wide16_value), 32'h1234);
    acc(IOW_WIDE16_ADDR, 1'b0, 1'b1, 8'h00);
    check(32'(rsp.rdata), 32'h34);
    acc(IOW_WIDE16_ADDR + 16'h1, 1'b1, 1'b0, 8'h56);
    acc(IOW_WIDE16_ADDR + 16'h1, 1'b0, 1'b1, 8'h00);
    check(32'(rsp.rdata), 32'h12);
    wait2();
    check(32'(wide16_value), 32'h5612);
    acc(IOW_WIDE16_ADDR, 1'b1, 1'b0, 8'h78);
    acc(IOW_WIDE16_ADDR + 16'h1, 1'b1, 1'b0, 8'h9a);
    wait2();
    check(32'(wide16_value), 32'h9a78);
  endtask
  task automatic t_wide32();
    logic [31:0] v;
    v = 32'h44332211;
    for (int b = 0; b < 3; b++) begin
      acc(IOW_WIDE32_ADDR + 16'(b), 1'b1, 1'b0, v[8*b+:8]);
    end
    wait2();
    check(wide32_value, 32'h0);
    acc(IOW_WIDE32_ADDR + 16'h3, 1'b1, 1'b0, v[31:24]);
    wait2();
    check(wide32_value, v);
    for (int b = 0; b < 4; b++) begin
      acc(IOW_WIDE32_ADDR + 16'(b), 1'b0, 1'b1, 8'h00);
      check(32'(rsp.rdata), 32'(v[8*b+:8]));
    end
  endtask
  task automatic t_stray();
    acc(16'h0040, 1'b1, 1'b0, 8'hff);
    acc(16'h0f00, 1'b1, 1'b0, 8'hff);
    acc(16'h0040, 1'b0, 1'b1, 8'h00);
    check(32'(rsp.rdata), 32'h0);
    acc(16'h001f, 1'b0, 1'b1, 8'h00);
    check(32'(rsp.rdata), 32'h87);
    check(32'(wide16_value), 32'h9a78);
    check(wide32_value, 32'h44332211);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check({rsp, sel_out, bit_test, 9'h0}, 32'h0);
    check({wide32_value}, 32'h0);
    check(32'(wide16_value), 32'h0);
    t_decode();
    t_low();
    t_wide16();
    t_wide32();
    t_stray();
    complete_run();
  end
  // a hang counts as a mismatch and still ends through the report
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule // testbench
